/* File: verilog/yydt_pkg.sv */
// Package of register map, field layout, reset values and timing for the yearly date timer.
package yydt_pkg;

	// ==========================================================================
	// Register byte offsets on the Wishbone bus.
	localparam logic [7:0] YYDT_CTRL_OFS = 8'h00;
	localparam logic [7:0] YYDT_ON_OFS = 8'h04;
	localparam logic [7:0] YYDT_OFF_OFS = 8'h08;
	localparam logic [7:0] YYDT_STAT_OFS = 8'h0C;
	localparam logic [7:0] YYDT_NOW_OFS = 8'h10;

	// ==========================================================================
	// Control register bit positions.
	localparam int YYDT_CTRL_EN_BIT = 0;
	localparam int YYDT_CTRL_MON_BIT = 1;
	localparam int YYDT_CTRL_YR_BIT = 2;
	localparam int YYDT_CTRL_PUL_BIT = 3;
	localparam int YYDT_CTRL_W = 4;

	// Status register bit positions.
	localparam int YYDT_STAT_OUT_BIT = 0;
	localparam int YYDT_STAT_ERR_BIT = 1;

	// ==========================================================================
	// Date key layout: year offset from 2000, then month, then day.
	localparam int YYDT_KEY_W = 16;
	localparam int YYDT_YEAR_LSB = 9;
	localparam int YYDT_YEAR_W = 7;
	localparam int YYDT_MONTH_LSB = 5;
	localparam int YYDT_MONTH_W = 4;
	localparam int YYDT_DAY_W = 5;
	localparam int YYDT_MD_W = 9;
	localparam logic [6:0] YYDT_YEAR_MAX = 7'h63;

	// ==========================================================================
	// Reset values.
	localparam logic [3:0] YYDT_CTRL_RST = 4'h0;
	localparam logic [15:0] YYDT_DATE_RST = 16'h0021;

	// ==========================================================================
	// Scan cycle timing.
	localparam int YYDT_CLK_PERIOD_NS = 10;
	localparam int YYDT_SCAN_TIME_US = 100;
	localparam int YYDT_SCAN_CYCLES = (YYDT_SCAN_TIME_US * 1000) / YYDT_CLK_PERIOD_NS;

	// Year field of a date key.
	function automatic logic [6:0] yydt_year(input logic [15:0] key);
		yydt_year = key[15:9];
	endfunction

	// Month and day fields of a date key.
	function automatic logic [8:0] yydt_md(input logic [15:0] key);
		yydt_md = key[8:0];
	endfunction

	// Day field of a date key.
	function automatic logic [4:0] yydt_day(input logic [15:0] key);
		yydt_day = key[4:0];
	endfunction

	// Byte-lane merge of a write into an old word.
	function automatic logic [31:0] yydt_merge(input logic [31:0] old, input logic [31:0] wr,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				res[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		yydt_merge = res;
	endfunction

endpackage

/* File: verilog/yydt_scan_div.sv */
// Divider that marks the program scan cycle with a one-cycle enable pulse.
`timescale 1ns/100ps
module yydt_scan_div
	import yydt_pkg::*;
#(
	parameter int SCAN_CYCLES = YYDT_SCAN_CYCLES
)
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Scan enable pulse.
	output logic tick_o
);

	// ==========================================================================
	// Divider state.
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} yydt_div_t;

	yydt_div_t st_r;
	yydt_div_t st_nxt;

	// Elaboration check: a scan shorter than two clocks cannot give a one-cycle pulse.
	if (SCAN_CYCLES < 2)
	begin : g_bad_scan
		$error("SCAN_CYCLES must be at least 2.");
	end

	// Count to the end of the scan period and pulse once.
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt == 32'(SCAN_CYCLES - 1))
		begin
			st_nxt.cnt = 32'h0;
			st_nxt.tick = 1'b1;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + 32'h1;
		end
	end

	// State register.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign tick_o = st_r.tick;

endmodule // yydt_scan_div

/* File: verilog/yydt_date_eval.sv */
// Combinational date comparison giving the switching level and the pulse hit.
`timescale 1ns/100ps
module yydt_date_eval
	import yydt_pkg::*;
(
	// Mode selection.
	input wire logic mon_i,
	input wire logic yr_i,
	// Dates as year, month, day keys.
	input wire logic [15:0] today_i,
	input wire logic [15:0] on_i,
	input wire logic [15:0] off_i,
	// Results.
	output logic level_o,
	output logic hit_o
);

	logic [6:0] y;
	logic [6:0] on_y;
	logic [6:0] off_y;
	logic yin;

	// Year window from the first active year to the final off year.
	assign y = yydt_year(today_i);
	assign on_y = yydt_year(on_i);
	assign off_y = yydt_year(off_i);
	assign yin = (y >= on_y) && (y <= off_y);

	// Level and hit for the selected recurrence; monthly wins over yearly.
	always_comb
	begin
		level_o = 1'b0;
		hit_o = 1'b0;
		if (mon_i)
		begin
			hit_o = yin && (yydt_day(today_i) == yydt_day(on_i));
			if (yydt_day(on_i) <= yydt_day(off_i))
			begin
				level_o = yin && (yydt_day(today_i) >= yydt_day(on_i))
					&& (yydt_day(today_i) < yydt_day(off_i));
			end
			else
			begin
				level_o = yin && ((yydt_day(today_i) >= yydt_day(on_i))
					|| (yydt_day(today_i) < yydt_day(off_i)));
			end
		end
		else if (yr_i)
		begin
			hit_o = yin && (yydt_md(today_i) == yydt_md(on_i));
			if (yydt_md(on_i) <= yydt_md(off_i))
			begin
				level_o = yin && (yydt_md(today_i) >= yydt_md(on_i))
					&& (yydt_md(today_i) < yydt_md(off_i));
			end
			else
			begin
				level_o = ((yydt_md(today_i) >= yydt_md(on_i)) && (y >= on_y) && (y < off_y))
					|| ((yydt_md(today_i) < yydt_md(off_i)) && (y > on_y) && (y <= off_y));
			end
		end
		else
		begin
			hit_o = (today_i == on_i);
			level_o = (today_i >= on_i) && (today_i < off_i);
		end
	end

endmodule // yydt_date_eval

/* File: verilog/yydt_timer.sv */
// Yearly date timer: Wishbone registers, scan-cycle evaluation and the switched output.
`timescale 1ns/100ps
module yydt_timer
	import yydt_pkg::*;
#(
	parameter int SCAN_CYCLES = YYDT_SCAN_CYCLES
)
(
	// Clock and reset.
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	// Wishbone classic slave.
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Current date from the real-time clock, same clock domain.
	input wire logic [6:0] DATE_YEAR_I,
	input wire logic [3:0] DATE_MONTH_I,
	input wire logic [4:0] DATE_DAY_I,
	// Switched output to program logic.
	output logic SWITCH_O
);

	// ==========================================================================
	// State of the block.
	typedef struct packed {
		logic [3:0] ctrl;
		logic [15:0] on_date;
		logic [15:0] off_date;
		logic [15:0] last_key;
		logic seen;
		logic out;
		logic err;
		logic ack;
		logic [31:0] rdat;
	} yydt_state_t;

	yydt_state_t st_r;
	yydt_state_t st_nxt;

	logic tick;
	logic [15:0] today;
	logic level;
	logic hit;
	logic en;
	logic mon;
	logic yr;
	logic pul;
	logic req;
	logic wr;
	logic new_day;
	logic [31:0] wr_word;

	// Elaboration check: a scan shorter than two clocks breaks the pulse timing.
	if (SCAN_CYCLES < 2)
	begin : g_bad_scan
		$error("SCAN_CYCLES must be at least 2.");
	end

	// ==========================================================================
	// Scan cycle divider and date comparison.
	// The divider restarts with reset, so the first tick lands one scan after release.
	yydt_scan_div #(
		.SCAN_CYCLES(SCAN_CYCLES)
	) u_div (
		.clk_i(CLOCK_I),
		.rst_i(RESET_I),
		.tick_o(tick)
	);

	// The comparison is combinational and only counts when a tick samples it.
	yydt_date_eval u_eval (
		.mon_i(mon),
		.yr_i(yr),
		.today_i(today),
		.on_i(st_r.on_date),
		.off_i(st_r.off_date),
		.level_o(level),
		.hit_o(hit)
	);

	// Decoded control, today's key and bus request.
	assign today = {DATE_YEAR_I, DATE_MONTH_I, DATE_DAY_I};
	assign en = st_r.ctrl[YYDT_CTRL_EN_BIT];
	assign mon = st_r.ctrl[YYDT_CTRL_MON_BIT];
	assign yr = st_r.ctrl[YYDT_CTRL_YR_BIT];
	assign pul = st_r.ctrl[YYDT_CTRL_PUL_BIT];
	assign req = WB_CYC_I && WB_STB_I && !st_r.ack;
	assign wr = req && WB_WE_I;
	assign new_day = tick && st_r.seen && (today != st_r.last_key);

	// ==========================================================================
	// Next-state logic: registers, bus answer and switching.
	always_comb
	begin
		st_nxt = st_r;
		wr_word = 32'h0;
		// The answer is registered, so ack follows one cycle after the request,
		// and the request term masks a second request while ack is still high.
		st_nxt.ack = req;
		// Register writes; a date with a year past the limit is refused.
		if (wr)
		begin
			unique case (WB_ADR_I)
				YYDT_CTRL_OFS:
				begin
					wr_word = yydt_merge({28'h0, st_r.ctrl}, WB_DAT_I, WB_SEL_I);
					st_nxt.ctrl = wr_word[3:0];
				end
				YYDT_ON_OFS:
				begin
					wr_word = yydt_merge({16'h0, st_r.on_date}, WB_DAT_I, WB_SEL_I);
					if (wr_word[15:9] <= YYDT_YEAR_MAX)
					begin
						st_nxt.on_date = wr_word[15:0];
					end
					else
					begin
						st_nxt.err = 1'b1;
					end
				end
				YYDT_OFF_OFS:
				begin
					wr_word = yydt_merge({16'h0, st_r.off_date}, WB_DAT_I, WB_SEL_I);
					if (wr_word[15:9] <= YYDT_YEAR_MAX)
					begin
						st_nxt.off_date = wr_word[15:0];
					end
					else
					begin
						st_nxt.err = 1'b1;
					end
				end
				YYDT_STAT_OFS:
				begin
					// Writing one clears the error flag.
					if (WB_SEL_I[0] && WB_DAT_I[YYDT_STAT_ERR_BIT])
					begin
						st_nxt.err = 1'b0;
					end
				end
				default:
				begin
					wr_word = 32'h0;
				end
			endcase
		end
		// A refused date in the same cycle keeps the error flag set.
		if (wr && ((WB_ADR_I == YYDT_ON_OFS) || (WB_ADR_I == YYDT_OFF_OFS))
			&& (wr_word[15:9] > YYDT_YEAR_MAX))
		begin
			st_nxt.err = 1'b1;
		end
		// Read data, unmapped addresses read as zero.
		st_nxt.rdat = 32'h0;
		if (req && !WB_WE_I)
		begin
			unique case (WB_ADR_I)
				YYDT_CTRL_OFS: st_nxt.rdat = {28'h0, st_r.ctrl};
				YYDT_ON_OFS: st_nxt.rdat = {16'h0, st_r.on_date};
				YYDT_OFF_OFS: st_nxt.rdat = {16'h0, st_r.off_date};
				YYDT_STAT_OFS: st_nxt.rdat = {30'h0, st_r.err, st_r.out};
				YYDT_NOW_OFS: st_nxt.rdat = {16'h0, today};
				default: st_nxt.rdat = 32'h0;
			endcase
		end
		// Disabling clears the seen flag, so the first tick after enabling only
		// records the date and a period already running is only switched on at the next new day.
		// Evaluation once per scan cycle while enabled.
		if (!en)
		begin
			st_nxt.seen = 1'b0;
			st_nxt.out = 1'b0;
		end
		else if (tick)
		begin
			st_nxt.seen = 1'b1;
			st_nxt.last_key = today;
			if (pul)
			begin
				// A pulse lasts one scan and only starts at a new day.
				st_nxt.out = new_day && hit;
			end
			else if (new_day)
			begin
				st_nxt.out = level;
			end
		end
	end

	// State register.
	// Reset loads each field with its default; the answer and the output start low.
	always_ff @(posedge CLOCK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			st_r.ctrl <= YYDT_CTRL_RST;
			st_r.on_date <= YYDT_DATE_RST;
			st_r.off_date <= YYDT_DATE_RST;
			st_r.last_key <= 16'h0000;
			st_r.seen <= 1'b0;
			st_r.out <= 1'b0;
			st_r.err <= 1'b0;
			st_r.ack <= 1'b0;
			st_r.rdat <= 32'h0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs.
	assign WB_ACK_O = st_r.ack;
	assign WB_DAT_O = st_r.rdat;
	assign SWITCH_O = st_r.out;

	// ==========================================================================
	// Checks on the switching and the register file.
	// The pulse checks rely on at least two clocks per scan, which the
	// elaboration check above guarantees.
	AST_SWITCH_ON_BOUNDARY: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(!$past(st_r.out) && st_r.out) |-> $past(tick && st_r.seen && en))
		else $error("Output rose outside a scan evaluation.");

	AST_PULSE_ONE_SCAN: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(pul && st_r.out && tick && !new_day) |=> !st_r.out)
		else $error("Pulse output outlived one scan cycle.");

	AST_YEAR_LIMIT: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(yydt_year(st_r.on_date) <= YYDT_YEAR_MAX) && (yydt_year(st_r.off_date) <= YYDT_YEAR_MAX))
		else $error("Stored date year beyond the limit.");

	AST_REFUSE_YEAR: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(wr && (WB_ADR_I == YYDT_ON_OFS) && (WB_SEL_I == 4'hF) && (WB_DAT_I[15:9] > YYDT_YEAR_MAX))
		|=> (st_r.err && $stable(st_r.on_date)))
		else $error("Out-of-range year was accepted.");

	AST_PERIOD_SET: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && !mon && !yr && !pul && new_day && (today == st_r.on_date)
			&& (st_r.on_date < st_r.off_date)) |=> st_r.out)
		else $error("Period did not start at the on date.");

	AST_YEARLY_SET: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && yr && !mon && !pul && new_day && (yydt_md(today) == yydt_md(st_r.on_date))
			&& (yydt_md(st_r.on_date) != yydt_md(st_r.off_date))
			&& (yydt_year(today) >= yydt_year(st_r.on_date))
			&& (yydt_year(today) < yydt_year(st_r.off_date))) |=> st_r.out)
		else $error("Yearly output did not switch on.");

	AST_MONTHLY_OFF: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && mon && !pul && new_day && (yydt_day(today) == yydt_day(st_r.off_date))
			&& (yydt_day(st_r.on_date) != yydt_day(st_r.off_date))) |=> !st_r.out)
		else $error("Monthly output did not switch off.");

	AST_FINAL_YEAR: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && (mon || yr) && new_day && (yydt_year(today) > yydt_year(st_r.off_date)))
		|=> !st_r.out)
		else $error("Output re-armed after the final year.");

	AST_SINGLE_PULSE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && pul && !mon && !yr && tick && (today != st_r.on_date)) |=> !st_r.out)
		else $error("Single pulse fired off its date.");

	AST_YEARLY_PULSE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && pul && yr && !mon && new_day && (yydt_md(today) == yydt_md(st_r.on_date))
			&& (yydt_year(today) >= yydt_year(st_r.on_date))
			&& (yydt_year(today) <= yydt_year(st_r.off_date))) |=> st_r.out ##1 st_r.out)
		else $error("Yearly pulse missing.");

	AST_MONTH_END_YEAR: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && mon && !pul && new_day && (yydt_year(today) == yydt_year(st_r.off_date))
			&& (yydt_day(today) == yydt_day(st_r.on_date))
			&& (yydt_day(st_r.on_date) != yydt_day(st_r.off_date))
			&& (yydt_year(today) >= yydt_year(st_r.on_date))) |=> st_r.out)
		else $error("Monthly pattern stopped before the final year.");

	AST_NO_RETRO_SET: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && !st_r.seen) |=> !st_r.out)
		else $error("Output set before a date was recorded.");

	AST_HOLD_BETWEEN_DAYS: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && !pul && !new_day) |=> $stable(st_r.out))
		else $error("Output changed without a new day.");

	AST_PERIOD_END: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && !mon && !yr && !pul && new_day && (today == st_r.off_date))
		|=> !st_r.out)
		else $error("Period did not end at the off date.");

	AST_YEARLY_WRAP_OFF: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && yr && !mon && !pul && new_day && (yydt_md(today) == yydt_md(st_r.off_date))
			&& (yydt_md(st_r.off_date) < yydt_md(st_r.on_date))) |=> !st_r.out)
		else $error("Wrapped yearly output did not switch off.");

	AST_MONTHLY_PULSE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(en && pul && mon && new_day && (yydt_day(today) == yydt_day(st_r.on_date))
			&& (yydt_year(today) >= yydt_year(st_r.on_date))
			&& (yydt_year(today) <= yydt_year(st_r.off_date))) |=> st_r.out)
		else $error("Monthly pulse missing.");

	AST_DISABLE_OFF: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		!en |=> !st_r.out)
		else $error("Output stayed on while disabled.");

	AST_TICK_SINGLE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		tick |=> !tick)
		else $error("Scan tick lasted more than one clock.");

	AST_ERR_STICKY: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(st_r.err && !(wr && (WB_ADR_I == YYDT_STAT_OFS))) |=> st_r.err)
		else $error("Error flag cleared without a write.");

	AST_REFUSE_OFF_YEAR: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(wr && (WB_ADR_I == YYDT_OFF_OFS) && (WB_SEL_I == 4'hF)
			&& (WB_DAT_I[15:9] > YYDT_YEAR_MAX))
		|=> (st_r.err && $stable(st_r.off_date)))
		else $error("Out-of-range off year was accepted.");

	// ==========================================================================
	// Checks on the bus answer.
	AST_ACK_PULSE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("Acknowledge held for more than one cycle.");

endmodule // yydt_timer

/* File: dv/yydt_prog_model.sv */
// Program-logic model that consumes the switched output and measures its pulses.
`timescale 1ns/100ps
module yydt_prog_model
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Switched output of the timer.
	input wire logic sw_i,
	// Count of rises and length of the last high run in clocks.
	output logic [15:0] rise_cnt_o,
	output logic [15:0] high_len_o
);
	logic sw_r;
	logic [15:0] run_r;

	// Scan-style sampling: count each rise and time each high run.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sw_r <= 1'b0;
			run_r <= 16'h0000;
			rise_cnt_o <= 16'h0000;
			high_len_o <= 16'h0000;
		end
		else
		begin
			sw_r <= sw_i;
			run_r <= sw_i ? run_r + 16'h0001 : 16'h0000;
			if (sw_i && !sw_r)
				rise_cnt_o <= rise_cnt_o + 16'h0001;
			if (!sw_i && sw_r)
				high_len_o <= run_r;
		end
	end
endmodule // yydt_prog_model

/* File: dv/yydt_timer_tb.sv */
// Self-checking testbench of the yearly date timer.
`timescale 1ns/100ps
module yydt_timer_tb
	import yydt_pkg::*;
;
	// Short scan period keeps the run brief.
	localparam int SC = 4;
	logic clk;
	logic rst;
	logic cyc;
	logic stb;
	logic we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w;
	logic [31:0] dat_r;
	logic ack;
	logic [6:0] yr;
	logic [3:0] mo;
	logic [4:0] dy;
	logic sw;
	logic [15:0] rise_cnt;
	logic [15:0] high_len;
	logic [15:0] r0;
	logic [31:0] rd;
	int fail_count;
	int n_compared;

	yydt_timer #(.SCAN_CYCLES(SC)) i_dut (.CLOCK_I(clk), .RESET_I(rst), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w),
		.WB_DAT_O(dat_r), .WB_ACK_O(ack), .DATE_YEAR_I(yr), .DATE_MONTH_I(mo),
		.DATE_DAY_I(dy), .SWITCH_O(sw));
	yydt_prog_model i_prog (.clk_i(clk), .rst_i(rst), .sw_i(sw), .rise_cnt_o(rise_cnt),
		.high_len_o(high_len));

	// Free-running 100 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Date key from hex bytes: year offset, month, day.
	function automatic logic [15:0] dk(input logic [23:0] v);
		return {v[22:16], v[11:8], v[4:0]};
	endfunction

	// Compare and count.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Classic Wishbone cycle: hold until ack is sampled, then idle one cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		sel <= 4'hF;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		check({31'h0, ack}, 32'h1);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	// Read one register and compare.
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	// Move the calendar to a new day, let three scans pass, check the output.
	task automatic day(input logic [15:0] k, input logic e);
		yr <= k[15:9];
		mo <= k[8:5];
		dy <= k[4:0];
		repeat (3 * SC) @(posedge clk);
		check({31'h0, sw}, {31'h0, e});
	endtask

	// Program mode and dates while disabled, then enable on a start date.
	task automatic cfg(input logic [3:0] c, input logic [23:0] on, off, st);
		wb(1'b1, YYDT_CTRL_OFS, 32'h0);
		wb(1'b1, YYDT_ON_OFS, {16'h0, dk(on)});
		wb(1'b1, YYDT_OFF_OFS, {16'h0, dk(off)});
		day(dk(st), 1'b0);
		wb(1'b1, YYDT_CTRL_OFS, {28'h0, c});
		repeat (3 * SC) @(posedge clk);
		r0 = rise_cnt;
	endtask

	// Pulses seen since the last configuration.
	task automatic pchk(input logic [15:0] n);
		check({16'h0, rise_cnt - r0}, {16'h0, n});
	endtask

	// Verdict and end of run.
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard well beyond the expected run length.
	initial
	begin
		repeat (30000) @(posedge clk);
		fail_count++;
		test_done;
	end

	// Main test sequence.
	initial
	begin
		fail_count = 0;
		n_compared = 0;
		rst <= 1'b1;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		adr <= 8'h00;
		sel <= 4'h0;
		dat_w <= 32'h0;
		yr <= 7'h00;
		mo <= 4'h1;
		dy <= 5'h01;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(YYDT_CTRL_OFS, 32'h0);
		rchk(YYDT_ON_OFS, 32'h21);
		rchk(YYDT_OFF_OFS, 32'h21);
		rchk(YYDT_STAT_OFS, 32'h0);
		rchk(8'h20, 32'h0);
		wb(1'b1, YYDT_ON_OFS, {16'h0, dk(24'h640101)});
		rchk(YYDT_ON_OFS, 32'h21);
		wb(1'b1, YYDT_OFF_OFS, {16'h0, dk(24'h7F0101)});
		rchk(YYDT_OFF_OFS, 32'h21);
		rchk(YYDT_STAT_OFS, 32'h2);
		wb(1'b1, YYDT_STAT_OFS, 32'h2);
		rchk(YYDT_STAT_OFS, 32'h0);
		wb(1'b1, YYDT_ON_OFS, {16'h0, dk(24'h630C1F)});
		rchk(YYDT_ON_OFS, {16'h0, dk(24'h630C1F)});
		$display("test registers done");
		cfg(4'h1, 24'h080601, 24'h0A081F, 24'h08051F);
		day(dk(24'h080601), 1'b1);
		rchk(YYDT_NOW_OFS, {16'h0, dk(24'h080601)});
		rchk(YYDT_STAT_OFS, 32'h1);
		wb(1'b1, YYDT_OFF_OFS, {16'h0, dk(24'h080601)});
		repeat (3 * SC) @(posedge clk);
		check({31'h0, sw}, 32'h1);
		wb(1'b1, YYDT_OFF_OFS, {16'h0, dk(24'h0A081F)});
		day(dk(24'h090C1F), 1'b1);
		day(dk(24'h0A081E), 1'b1);
		day(dk(24'h0A081F), 1'b0);
		$display("test period done");
		cfg(4'h7, 24'h080101, 24'h0A0105, 24'h070B1E);
		day(dk(24'h070C01), 1'b0);
		day(dk(24'h080301), 1'b1);
		day(dk(24'h080305), 1'b0);
		day(dk(24'h0A0C01), 1'b1);
		day(dk(24'h0B0101), 1'b0);
		$display("test monthly done");
		cfg(4'h5, 24'h080C0F, 24'h0A0107, 24'h080C0E);
		day(dk(24'h080C0F), 1'b1);
		day(dk(24'h090106), 1'b1);
		day(dk(24'h090107), 1'b0);
		day(dk(24'h090C0F), 1'b1);
		day(dk(24'h0A0107), 1'b0);
		day(dk(24'h0A0C0F), 1'b0);
		$display("test yearly done");
		cfg(4'h9, 24'h08030F, 24'h08030F, 24'h08030E);
		day(dk(24'h08030F), 1'b0);
		pchk(16'h1);
		check({16'h0, high_len}, 32'(SC));
		day(dk(24'h09030F), 1'b0);
		pchk(16'h1);
		cfg(4'hD, 24'h08030F, 24'h0A0101, 24'h0A030E);
		day(dk(24'h0A030F), 1'b0);
		pchk(16'h1);
		day(dk(24'h0B030F), 1'b0);
		pchk(16'h1);
		cfg(4'hB, 24'h08010A, 24'h080101, 24'h080509);
		day(dk(24'h08050A), 1'b0);
		day(dk(24'h08060A), 1'b0);
		pchk(16'h2);
		$display("test pulse done");
		test_done;
	end
endmodule // yydt_timer_tb
